// file: logic/rcf_map.svh
/*
 * Register map and fixed values of the reset cause flags block.
 * Assumes inclusion by bare name from any file that needs the layout.
 */
`ifndef RCF_MAP_SVH
`define RCF_MAP_SVH

// ==========================================================================
// Register location
`define RCF_CAUSE_ADDR 8'hFA
`define RCF_CAUSE_BANK 1'h1

// ==========================================================================
// Field positions
`define RCF_PIN_BIT 2
`define RCF_WDOG_BIT 1
`define RCF_LOWV_BIT 0

// ==========================================================================
// Values
`define RCF_FLAGS_RST 3'h0
`define RCF_LOWV_PATTERN 3'h1
`define RCF_UNUSED_READ 5'h00
`define RCF_RDATA_RST 8'h00
// Synchroniser idle levels: bit 0 pin (high idle), bit 1 low-voltage (low idle)
`define RCF_SYNC_IDLE 2'h1

`endif

// file: logic/rcf_pkg.sv
/*
 * Types shared by the reset cause flags block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package rcf_pkg;
    typedef logic [7:0] rcf_byte_t;
    typedef logic [2:0] rcf_flags_t;
endpackage : rcf_pkg

`default_nettype wire

// file: logic/rcf_sync.sv
/*
 * Two-stage synchroniser for one asynchronous level.
 * Assumes the input may change at any time relative to ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module rcf_sync #(
    parameter logic RST_VAL = 1'h0
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;

    // ======================================================================
    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : rcf_sync

`default_nettype wire

// file: logic/rcf_top.sv
/*
 * Reset cause flags: a byte register recording which sources caused resets
 * since the flags were last cleared (external pin, watchdog, low-voltage detector).
 * Assumes rst_b_i is the power-on reset of this block only, so the flags
 * survive the pin and watchdog resets that they record. The watchdog
 * request comes from logic on ref_clk_i; pin and low-voltage inputs are
 * asynchronous. Register port is the core's register-addressing port.
 */
// Overview of operation
// - Bit 2 reads 1 after a reset driven by the external active-low pin, until a 0 write or a low-voltage reset clears it.
// - A low-voltage reset forces the three flags to pin 0, watchdog 0, low-voltage 1.
// - On a pin or watchdog reset with no low-voltage reset in the same cycle, every source active at that moment gets its flag set.
// - Pin and watchdog resets leave the low-voltage flag untouched.
// - Writing 0 to a flag bit clears that flag.
// - Writing 1 to a flag bit neither sets nor clears it.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

module rcf_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic external_reset_pin_n_i,
    input wire logic watchdog_reset_source_i,
    input wire logic low_voltage_reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_bank_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire rcf_pkg::rcf_byte_t reg_wdata_i,
    output var rcf_pkg::rcf_byte_t reg_rdata_o,
    output var rcf_pkg::rcf_flags_t reset_cause_o
);
    import rcf_pkg::*;

    logic [1:0] async_raw;
    logic [1:0] async_sync;
    logic pin_act;
    logic wdog_act;
    logic lowv_act;
    logic reg_hit;
    logic wr_hit;
    logic rd_hit;
    rcf_flags_t flags;
    rcf_flags_t next_flags;

    // ======================================================================
    // Input synchronisers
    assign async_raw = {low_voltage_reset_i, external_reset_pin_n_i};

    localparam logic [1:0] SYNC_IDLE = `RCF_SYNC_IDLE;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            rcf_sync #(
                .RST_VAL(SYNC_IDLE[gi])
            ) u_sync (
                .ref_clk_i(ref_clk_i),
                .rst_b_i(rst_b_i),
                .d_i(async_raw[gi]),
                .q_o(async_sync[gi])
            );
        end
    endgenerate

    assign pin_act = ~async_sync[0];
    assign lowv_act = async_sync[1];
    // Same-clock source, so no synchroniser
    assign wdog_act = watchdog_reset_source_i;

    // ======================================================================
    // Register decode
    assign reg_hit = (reg_addr_i == `RCF_CAUSE_ADDR) && (reg_bank_i == `RCF_CAUSE_BANK);
    assign wr_hit = reg_hit && reg_wr_i;
    assign rd_hit = reg_hit && reg_rd_i;

    // ======================================================================
    // Flag update
    // Order of precedence: software clear, then source set, then the
    // low-voltage pattern; a set in the clearing cycle is therefore kept.
    always_comb begin
        next_flags = flags;
        if (wr_hit) begin
            next_flags = flags & reg_wdata_i[2:0];
        end
        if (pin_act) begin
            next_flags[`RCF_PIN_BIT] = 1'h1;
        end
        if (wdog_act) begin
            next_flags[`RCF_WDOG_BIT] = 1'h1;
        end
        if (lowv_act) begin
            next_flags = `RCF_LOWV_PATTERN;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags <= `RCF_FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reset_cause_o <= `RCF_FLAGS_RST;
        end else begin
            reset_cause_o <= next_flags;
        end
    end

    // ======================================================================
    // Read data
    // Held between reads, so the core may sample it late.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= `RCF_RDATA_RST;
        end else if (rd_hit) begin
            reg_rdata_o <= {`RCF_UNUSED_READ, flags};
        end
    end

    // ======================================================================
    // Assertions
    sequence s_quiet;
        !pin_act && !wdog_act && !lowv_act;
    endsequence

    sequence s_write_hit;
        wr_hit ##0 s_quiet;
    endsequence

    sequence s_read_hit;
        rd_hit;
    endsequence

    sequence s_lowv_held;
        lowv_act ##1 lowv_act;
    endsequence

    property p_pin_sets;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        pin_act && !lowv_act |=> flags[`RCF_PIN_BIT] && reset_cause_o[`RCF_PIN_BIT];
    endproperty
    a_pin_sets: assert property (p_pin_sets)
        else $error("pin reset did not set the pin flag");

    property p_wdog_sets;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wdog_act && !lowv_act |=> flags[`RCF_WDOG_BIT];
    endproperty
    a_wdog_sets: assert property (p_wdog_sets)
        else $error("watchdog reset did not set the watchdog flag");

    property p_lowv_sets;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(lowv_act) |=> flags[`RCF_LOWV_BIT] && reset_cause_o[`RCF_LOWV_BIT];
    endproperty
    a_lowv_sets: assert property (p_lowv_sets)
        else $error("low-voltage reset did not set its flag");

    property p_lowv_pattern;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_lowv_held |=> flags == `RCF_LOWV_PATTERN;
    endproperty
    a_lowv_pattern: assert property (p_lowv_pattern)
        else $error("low-voltage reset did not give pattern 001");

    property p_both_set;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        pin_act && wdog_act && !lowv_act |=> flags[2:1] == 2'h3;
    endproperty
    a_both_set: assert property (p_both_set)
        else $error("simultaneous pin and watchdog did not set both flags");

    property p_lowv_kept;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !lowv_act && !(wr_hit && !reg_wdata_i[`RCF_LOWV_BIT])
            |=> $stable(flags[`RCF_LOWV_BIT]);
    endproperty
    a_lowv_kept: assert property (p_lowv_kept)
        else $error("low-voltage flag changed without cause");

    property p_zero_clears;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_write_hit ##0 (reg_wdata_i[2:0] == 3'h0) |=>
            (flags == 3'h0) ##1 (reg_rdata_o[2:0] == 3'h0 || !$past(rd_hit));
    endproperty
    a_zero_clears: assert property (p_zero_clears)
        else $error("writing zero did not clear the flags");

    property p_one_ignored;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_write_hit ##0 (reg_wdata_i == 8'hFF) |=> $stable(flags);
    endproperty
    a_one_ignored: assert property (p_one_ignored)
        else $error("writing one changed a flag");

    property p_read_back;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_hit |=> reg_rdata_o == {5'h00, $past(flags)};
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read data wrong or upper bits not zero");

    // Without any source active no flag may rise
    property p_no_spurious;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_quiet |=> (flags & ~$past(flags)) == 3'h0;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("a flag rose with no reset source active");

    property p_stray_write;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && !reg_hit) ##0 s_quiet |=> $stable(flags);
    endproperty
    a_stray_write: assert property (p_stray_write)
        else $error("write to another address changed the flags");

    property p_rdata_holds;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !rd_hit |=> $stable(reg_rdata_o);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data changed without a read");

endmodule : rcf_top

`default_nettype wire

// file: test/testbench.sv
/*
 * Self-checking bench for the reset cause flags block.
 * Assumes the rcf_pkg package and the rcf_top design are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rcf_pkg::*;
    logic ref_clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic pin_n = 1'h1;
    logic wdog = 1'h0;
    logic lowv = 1'h0;
    logic [7:0] addr = 8'h00;
    logic bank = 1'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    rcf_byte_t wdata = 8'h00;
    rcf_byte_t rdata;
    rcf_flags_t cause;
    rcf_byte_t exp_q[$];
    logic hit_d = 1'h0;
    int err_total = 0;
    int total_checks = 0;
    logic [31:0] lfsr = 32'h00012755;
    logic [2:0] model;

    rcf_top rcf_top_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .external_reset_pin_n_i(pin_n), .watchdog_reset_source_i(wdog),
        .low_voltage_reset_i(lowv), .reg_addr_i(addr), .reg_bank_i(bank),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reset_cause_o(cause));

    always #12.5 ref_clk_i = ~ref_clk_i;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction : lfsr_next

    task automatic check(input rcf_byte_t seen, input rcf_byte_t expv);
        total_checks++;
        if (seen !== expv) begin
            err_total++;
            $display("BAD %0t read %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Bus strobes last one cycle; the second edge lowers them
    task automatic access(input logic is_wr, input logic [7:0] a, input logic b,
                          input rcf_byte_t d);
        @(posedge ref_clk_i);
        addr <= a;
        bank <= b;
        wdata <= d;
        wr <= is_wr;
        rd <= ~is_wr;
        @(posedge ref_clk_i);
        wr <= 1'h0;
        rd <= 1'h0;
    endtask : access

    task automatic read_exp(input logic [2:0] f);
        exp_q.push_back({5'h00, f});
        access(1'h0, 8'hFA, 1'h1, 8'h00);
    endtask : read_exp

    // Sources held three cycles, then released long enough for the sync path
    task automatic source(input logic p, input logic w, input logic l);
        @(posedge ref_clk_i);
        pin_n <= ~p;
        wdog <= w;
        lowv <= l;
        repeat (3) @(posedge ref_clk_i);
        pin_n <= 1'h1;
        wdog <= 1'h0;
        lowv <= 1'h0;
        repeat (5) @(posedge ref_clk_i);
    endtask : source

    // Read data lands on the same edge that takes the read strobe
    always @(posedge ref_clk_i) begin
        hit_d <= rd && addr == 8'hFA && bank == 1'h1;
    end

    always @(negedge ref_clk_i) begin
        if (hit_d && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end
    end

    initial begin
        #(25 * 3000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_b_i <= 1'h1;
        read_exp(3'h0);
        source(1'h0, 1'h0, 1'h1);
        read_exp(3'h1);
        source(1'h1, 1'h0, 1'h0);
        read_exp(3'h5);
        source(1'h0, 1'h1, 1'h0);
        read_exp(3'h7);
        @(negedge ref_clk_i);
        check({5'h00, cause}, 8'h07);
        $display("test sources done");
        access(1'h1, 8'hFA, 1'h1, 8'hFF);
        read_exp(3'h7);
        access(1'h1, 8'hFA, 1'h0, 8'h00);
        access(1'h1, 8'hF9, 1'h1, 8'h00);
        read_exp(3'h7);
        source(1'h0, 1'h0, 1'h1);
        read_exp(3'h1);
        access(1'h1, 8'hFA, 1'h1, 8'hFE);
        read_exp(3'h0);
        source(1'h1, 1'h1, 1'h0);
        read_exp(3'h6);
        access(1'h1, 8'hFA, 1'h1, 8'hFB);
        read_exp(3'h2);
        access(1'h1, 8'hFA, 1'h1, 8'hF8);
        read_exp(3'h0);
        $display("test clears done");
        model = 3'h7;
        source(1'h0, 1'h0, 1'h1);
        source(1'h1, 1'h1, 1'h0);
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            model = model & lfsr[2:0];
            access(1'h1, 8'hFA, 1'h1, lfsr[7:0]);
            read_exp(model);
            if (model == 3'h0) begin
                source(1'h0, 1'h0, 1'h1);
                source(lfsr[9], 1'h1, 1'h0);
                model = {lfsr[9], 2'h3};
            end
        end
        $display("test random writes done");
        repeat (4) @(posedge ref_clk_i);
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
